// ---- gpp_consts.svh ----
// Register offsets, reset values and timing counts of the GPIO port
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_OFS_OUT     8'h00
`define GPP_OFS_DIR     8'h04
`define GPP_OFS_LVL     8'h08
`define GPP_OFS_IT1     8'h0C
`define GPP_OFS_IT2     8'h10
`define GPP_OFS_IST     8'h14
`define GPP_OFS_CLK     8'h18
`define GPP_RST_OUT     16'h0000
`define GPP_RST_DIR     16'h7FFF
`define GPP_RST_IT      24'h000000
`define GPP_RST_CLK     25'h1100000
`define GPP_BIT_PIN15_SOURCE_SELECT   24
`define GPP_BIT_PIN14_SOURCE_SELECT   8
`define GPP_LVL_CYCLES  3'h5
`endif

// ---- gpp_pkg.sv ----
// Types shared by the GPIO port modules
package gpp_pkg;
  typedef struct packed {
    logic       mux;
    logic [3:0] tc;
    logic [3:0] dc;
  } gpp_clk_cfg_t;
  typedef enum logic [2:0] {
    GPP_IT_HIGH = 3'h0,
    GPP_IT_LOW  = 3'h1,
    GPP_IT_RISE = 3'h2,
    GPP_IT_FALL = 3'h3,
    GPP_IT_BOTH = 3'h4
  } gpp_itype_t;
endpackage : gpp_pkg

// ---- gpp_clkgen.sv ----
// Programmable clock divider for the clock-capable pins
`timescale 1ns/10ps
module gpp_clkgen (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  // Configuration
  input  wire gpp_pkg::gpp_clk_cfg_t cfg_in,
  // Generated clock
  output logic                      clk_gen_out
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       clk_q;
  logic       clk_d;

  // Period is tc+1 system cycles, low for dc+1 of them; tc of zero holds high
  always_comb
  begin
    cnt_d = (cnt_q >= cfg_in.tc) ? 4'h0 : cnt_q + 4'h1;
    clk_d = (cfg_in.tc == 4'h0) ? 1'b1 : (cnt_d > cfg_in.dc);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign clk_gen_out = clk_q;
endmodule : gpp_clkgen

// ---- gpp_port.sv ----
// Sixteen-pin GPIO port with APB registers, edge/level detect, clock pins
// Functional notes
// - Sixteen pins, each input or output
// - Pin 14 is input after reset
// - Pin 15 drives clock after reset
// - Pins 14, 15 drive programmable clock
// - Pin 15 reset clock feeds expansion bus
// - Detect high, low, rise, fall, either
// - All readable; input level not writable
// - Direction bit n maps to pin n
// - Direction 0 output, 1 input
// - Output pins drive output data bits
// - Output data ignored on input pins
// - Input register shows every pin level
// - Output pins read back driven level
// - Source select: data or generated clock
`timescale 1ns/10ps
`include "gpp_consts.svh"
module gpp_port #(
  parameter int NPINS = 16
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Pins
  input  wire logic [NPINS-1:0]  gpio_in_in,
  output logic      [NPINS-1:0]  gpio_out_out,
  output logic      [NPINS-1:0]  gpio_oe_out,
  // Detected pin events for the system interrupt controller
  output logic      [NPINS-1:0]  int_status_out
);
  logic             rst_s1_q;
  logic             rst_n;
  logic [NPINS-1:0] in_s1_q;
  logic [NPINS-1:0] in_s2_q;
  logic [NPINS-1:0] prev_q;
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] out_d;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] dir_d;
  logic [23:0]      it1_q;
  logic [23:0]      it1_d;
  logic [23:0]      it2_q;
  logic [23:0]      it2_d;
  logic [NPINS-1:0] ist_q;
  logic [NPINS-1:0] ist_d;
  logic [24:0]      clk_cfg_q;
  logic [24:0]      clk_cfg_d;
  logic [2:0]       cnt_q [NPINS];
  logic [2:0]       cnt_d [NPINS];
  logic [31:0]      rd_q;
  logic [31:0]      rd_d;
  logic             err_q;
  logic             err_d;
  logic             started_q;
  logic [1:0]       gclk;
  logic             wr;
  logic             setup;
  logic             mapped;

  function automatic logic [2:0] pin_type(input logic [23:0] a,
                                          input logic [23:0] b,
                                          input int          n);
    logic [47:0] all;
    all = {b, a};
    return all[3*n +: 3];
  endfunction : pin_type

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : is_reg

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Pin levels are asynchronous; the second stage is used, and its delayed copy prev_q for edges
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      prev_q  <= '0;
    end
    else
    begin
      in_s1_q <= gpio_in_in;
      in_s2_q <= in_s1_q;
      prev_q  <= in_s2_q;
    end
  end

  // Clock sources for pins 14 and 15
  gpp_clkgen u_clk14 (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n),
    .cfg_in      (gpp_pkg::gpp_clk_cfg_t'({1'b0, clk_cfg_q[7:0]})),
    .clk_gen_out (gclk[0])
  );
  gpp_clkgen u_clk15 (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n),
    .cfg_in      (gpp_pkg::gpp_clk_cfg_t'({1'b0, clk_cfg_q[23:16]})),
    .clk_gen_out (gclk[1])
  );

  assign setup  = psel_in && !penable_in;
  assign wr     = psel_in && penable_in && pwrite_in;
  assign mapped = is_reg(paddr_in, `GPP_OFS_OUT) ||
                  is_reg(paddr_in, `GPP_OFS_DIR) ||
                  is_reg(paddr_in, `GPP_OFS_LVL) ||
                  is_reg(paddr_in, `GPP_OFS_IT1) ||
                  is_reg(paddr_in, `GPP_OFS_IT2) ||
                  is_reg(paddr_in, `GPP_OFS_IST) ||
                  is_reg(paddr_in, `GPP_OFS_CLK);

  always_comb
  begin
    logic [2:0] t;
    logic       hit;
    logic       lvl;
    t     = 3'h0;
    hit   = 1'b0;
    lvl   = 1'b0;
    out_d     = out_q;
    dir_d     = dir_q;
    it1_d     = it1_q;
    it2_d     = it2_q;
    clk_cfg_d = clk_cfg_q;
    ist_d     = ist_q;
    rd_d      = rd_q;
    err_d     = err_q;
    if (wr && is_reg(paddr_in, `GPP_OFS_OUT))
      out_d = pwdata_in[NPINS-1:0];
    if (wr && is_reg(paddr_in, `GPP_OFS_DIR))
      dir_d = pwdata_in[NPINS-1:0];
    if (wr && is_reg(paddr_in, `GPP_OFS_IT1))
      it1_d = pwdata_in[23:0];
    if (wr && is_reg(paddr_in, `GPP_OFS_IT2))
      it2_d = pwdata_in[23:0];
    if (wr && is_reg(paddr_in, `GPP_OFS_CLK))
      clk_cfg_d = pwdata_in[24:0];
    if (wr && is_reg(paddr_in, `GPP_OFS_IST))
      ist_d = ist_q & ~pwdata_in[NPINS-1:0];
    // Level types need five steady cycles to reject glitches
    for (int n = 0; n < NPINS; n++)
    begin
      t   = pin_type(it1_q, it2_q, n);
      lvl = (t == gpp_pkg::GPP_IT_HIGH) ? in_s2_q[n] : !in_s2_q[n];
      cnt_d[n] = !lvl ? 3'h0 :
                 (cnt_q[n] == `GPP_LVL_CYCLES) ? cnt_q[n] : cnt_q[n] + 3'h1;
      if (t[2])
        hit = in_s2_q[n] != prev_q[n];
      else if (t == gpp_pkg::GPP_IT_RISE)
        hit = in_s2_q[n] && !prev_q[n];
      else if (t == gpp_pkg::GPP_IT_FALL)
        hit = !in_s2_q[n] && prev_q[n];
      else
        hit = cnt_d[n] == `GPP_LVL_CYCLES;
      // Set wins over a same-cycle clear
      if (hit)
        ist_d[n] = 1'b1;
    end
    // Read data and error are fixed in the setup phase
    if (setup)
    begin
      rd_d  = 32'h0;
      err_d = !mapped || (pwrite_in && is_reg(paddr_in, `GPP_OFS_LVL));
      case (paddr_in)
        `GPP_OFS_OUT: rd_d[NPINS-1:0] = out_q;
        `GPP_OFS_DIR: rd_d[NPINS-1:0] = dir_q;
        `GPP_OFS_LVL: rd_d[NPINS-1:0] = in_s2_q;
        `GPP_OFS_IT1: rd_d[23:0]      = it1_q;
        `GPP_OFS_IT2: rd_d[23:0]      = it2_q;
        `GPP_OFS_IST: rd_d[NPINS-1:0] = ist_q;
        `GPP_OFS_CLK: rd_d[24:0]      = clk_cfg_q;
        default:      rd_d            = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q     <= `GPP_RST_OUT;
      dir_q     <= `GPP_RST_DIR;
      it1_q     <= `GPP_RST_IT;
      it2_q     <= `GPP_RST_IT;
      clk_cfg_q <= `GPP_RST_CLK;
      ist_q     <= '0;
      rd_q      <= 32'h0;
      err_q     <= 1'b0;
      started_q <= 1'b0;
      for (int n = 0; n < NPINS; n++)
        cnt_q[n] <= 3'h0;
    end
    else
    begin
      out_q     <= out_d;
      dir_q     <= dir_d;
      it1_q     <= it1_d;
      it2_q     <= it2_d;
      clk_cfg_q <= clk_cfg_d;
      ist_q     <= ist_d;
      rd_q      <= rd_d;
      err_q     <= err_d;
      started_q <= 1'b1;
      cnt_q     <= cnt_d;
    end
  end

  // Pin drive: enable only for outputs; input pins keep stored data undriven
  always_comb
  begin
    gpio_oe_out  = ~dir_q;
    gpio_out_out = out_q;
    if (clk_cfg_q[`GPP_BIT_PIN14_SOURCE_SELECT])
      gpio_out_out[14] = gclk[0];
    if (clk_cfg_q[`GPP_BIT_PIN15_SOURCE_SELECT])
      gpio_out_out[15] = gclk[1];
  end

  assign prdata_out     = rd_q;
  assign pslverr_out    = err_q && psel_in && penable_in;
  assign pready_out     = 1'b1;
  assign int_status_out = ist_q;

  sequence s_dir_write;
    wr && is_reg(paddr_in, `GPP_OFS_DIR);
  endsequence
  sequence s_high_held;
    (pin_type(it1_q, it2_q, 0) == 3'h0 && in_s2_q[0])[*5];
  endsequence

  property p_dir_oe;
    @(posedge clk_sys_in) disable iff (!rst_n)
    s_dir_write |=> gpio_oe_out == ~$past(pwdata_in[NPINS-1:0]);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("direction write did not reach output enables");

  property p_out_write;
    @(posedge clk_sys_in) disable iff (!rst_n)
    wr && is_reg(paddr_in, `GPP_OFS_OUT) |=>
      gpio_out_out[13:0] == $past(pwdata_in[13:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output data write did not reach pins");

  property p_sync;
    @(posedge clk_sys_in) disable iff (!rst_n)
    started_q ##2 1'b1 |-> in_s2_q == $past(gpio_in_in, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin synchronizer depth wrong");

  property p_rd_level;
    @(posedge clk_sys_in) disable iff (!rst_n)
    setup && is_reg(paddr_in, `GPP_OFS_LVL) |=>
      prdata_out == {16'h0000, $past(in_s2_q)};
  endproperty
  a_rd_level: assert property (p_rd_level)
    else $error("input level read wrong");

  property p_rise;
    @(posedge clk_sys_in) disable iff (!rst_n)
    pin_type(it1_q, it2_q, 0) == 3'h2 && in_s2_q[0] && !prev_q[0]
      |=> ist_q[0];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge not latched");

  property p_level;
    @(posedge clk_sys_in) disable iff (!rst_n)
    s_high_held |=> ist_q[0];
  endproperty
  a_level: assert property (p_level)
    else $error("held high level not latched");

  property p_ro_err;
    @(posedge clk_sys_in) disable iff (!rst_n)
    setup && pwrite_in && is_reg(paddr_in, `GPP_OFS_LVL) ##1
      (psel_in && penable_in) |-> pslverr_out;
  endproperty
  a_ro_err: assert property (p_ro_err)
    else $error("write to input level not refused");

  // Pin 15 on its clock source with terminal count 1 must toggle each cycle
  sequence s_fast_clk15;
    (clk_cfg_q[24:16] == 9'h110)[*3];
  endsequence

  property p_pin15_source_select;
    @(posedge clk_sys_in) disable iff (!rst_n)
    s_fast_clk15 |-> gpio_out_out[15] != $past(gpio_out_out[15]);
  endproperty
  a_pin15_source_select: assert property (p_pin15_source_select)
    else $error("pin 15 not following generated clock");

  property p_reset_cfg;
    @(posedge clk_sys_in) disable iff (!rst_n)
    !started_q |-> dir_q[15:14] == 2'b01 && clk_cfg_q[`GPP_BIT_PIN15_SOURCE_SELECT];
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("pins 14 and 15 reset setup wrong");
endmodule : gpp_port

// ---- gpp_board_model.sv ----
// Board model: resolves each pin from the port drive and the board drive
`timescale 1ns/10ps
module gpp_board_model (
  // Clock
  input  wire logic        clk_sys_in,
  // Port side
  input  wire logic [15:0] gpio_out_in,
  input  wire logic [15:0] gpio_oe_in,
  // Board side
  input  wire logic [15:0] ext_level_in,
  input  wire logic [15:0] ext_en_in,
  output logic      [15:0] pad_out
);
  logic [15:0] last_q;

  // A floating pin flips each cycle so a stale level never passes
  always_ff @(posedge clk_sys_in)
    last_q <= pad_out;

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (gpio_oe_in[i])
        pad_out[i] = gpio_out_in[i];
      else if (ext_en_in[i])
        pad_out[i] = ext_level_in[i];
      else
        pad_out[i] = ~last_q[i];
    end
  end
endmodule : gpp_board_model

// ---- gpp_port_tb_top.sv ----
// Self-checking testbench of the GPIO port
`timescale 1ns/10ps
`include "gpp_consts.svh"
module gpp_port_tb_top;
  logic        clk_sys_in;
  logic        rstn_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] gout;
  logic [15:0] goe;
  logic [15:0] ist;
  logic [15:0] pad;
  logic [15:0] ext;
  logic [15:0] ext_en;
  logic [31:0] rd;
  logic        err;
  logic        rdy;
  logic        st;
  int          err_count;
  int          samples_checked;
  int          n;

  gpp_port #(.NPINS(16)) uut (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .psel_in        (psel),
    .penable_in     (penable),
    .pwrite_in      (pwrite),
    .paddr_in       (paddr),
    .pwdata_in      (pwdata),
    .prdata_out     (prdata),
    .pready_out     (pready),
    .pslverr_out    (pslverr),
    .gpio_in_in     (pad),
    .gpio_out_out   (gout),
    .gpio_oe_out    (goe),
    .int_status_out (ist)
  );

  gpp_board_model board (
    .clk_sys_in   (clk_sys_in),
    .gpio_out_in  (gout),
    .gpio_oe_in   (goe),
    .ext_level_in (ext),
    .ext_en_in    (ext_en),
    .pad_out      (pad)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // No wait states, so the access phase always ends at its first edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys_in);
    psel = 1'h1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk_sys_in);
    penable = 1'h1;
    @(posedge clk_sys_in);
    rd = prdata;
    err = pslverr;
    rdy = pready;
    @(negedge clk_sys_in);
    psel = 1'h0;
    penable = 1'h0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdy, 1'h1);
    chk(err, 1'h0);
    chk(rd, e);
  endtask : rdc

  // Counts level changes of one pin over eight cycles
  task automatic tog(input int b);
    logic p;
    n = 0;
    @(negedge clk_sys_in);
    p = gout[b];
    repeat (8)
    begin
      @(negedge clk_sys_in);
      if (gout[b] !== p)
        n++;
      p = gout[b];
    end
  endtask : tog

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    clk_sys_in = 1'h0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    err_count++;
    close_out();
  end

  initial
  begin
    rstn_in = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 16'hAB37;
    ext_en = 16'hFFFF;
    err_count = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk_sys_in);
    rstn_in = 1'h1;
    repeat (4) @(negedge clk_sys_in);
    chk(goe, 16'h8000);
    tog(15);
    chk(n, 8);
    rdc(`GPP_OFS_DIR, `GPP_RST_DIR);
    rdc(`GPP_OFS_OUT, `GPP_RST_OUT);
    rdc(`GPP_OFS_CLK, `GPP_RST_CLK);
    done("reset");
    apb(1'h1, `GPP_OFS_DIR, 32'hFFFFFAFF);
    chk(goe, 16'h0500);
    apb(1'h1, `GPP_OFS_OUT, 32'hFFFF0401);
    chk({gout[10], gout[8]}, 2'h2);
    chk(goe[0], 1'h0);
    rdc(`GPP_OFS_OUT, 32'h00000401);
    repeat (3) @(negedge clk_sys_in);
    rdc(`GPP_OFS_LVL, 32'h0000AE37);
    apb(1'h1, `GPP_OFS_LVL, 32'h0);
    chk(err, 1'h1);
    rdc(`GPP_OFS_LVL, 32'h0000AE37);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    done("direction");
    apb(1'h1, `GPP_OFS_DIR, 32'h0);
    apb(1'h1, `GPP_OFS_OUT, 32'hC000);
    apb(1'h1, `GPP_OFS_CLK, 32'h110);
    chk(gout[15], 1'h1);
    repeat (2) @(negedge clk_sys_in);
    tog(14);
    chk(n, 8);
    apb(1'h1, `GPP_OFS_CLK, 32'h0);
    chk(gout, 16'hC000);
    chk(goe, 16'hFFFF);
    done("clock");
    apb(1'h1, `GPP_OFS_DIR, 32'hFFFF);
    for (int c = 0; c < 5; c++)
    begin
      st = (c == 1 || c == 3);
      ext[0] = st;
      apb(1'h1, `GPP_OFS_IT1, 32'(c));
      repeat (10) @(negedge clk_sys_in);
      apb(1'h1, `GPP_OFS_IST, 32'h1);
      repeat (3) @(negedge clk_sys_in);
      chk(ist[0], 1'h0);
      ext[0] = ~st;
      @(negedge clk_sys_in);
      chk(ist[0], 1'h0);
      repeat (9) @(negedge clk_sys_in);
      chk(ist[0], 1'h1);
      ext[0] = st;
      repeat (10) @(negedge clk_sys_in);
      apb(1'h1, `GPP_OFS_IST, 32'h1);
      chk(ist[0], 1'h0);
    end
    done("interrupts");
    // Upper bits beyond the 24-bit type field must read back as zero
    apb(1'h1, `GPP_OFS_IT2, 32'hFFFFFFFF);
    rdc(`GPP_OFS_IT2, 32'h00FFFFFF);
    rdc(`GPP_OFS_IT1, 32'h00000004);
    done("types");
    close_out();
  end
endmodule : gpp_port_tb_top
